// file: hw/acc_pkg.sv
package acc_pkg;

  // Host serial port.
  localparam logic [6:0] I2C_DEV_ADDR   = 7'h6a;

  // Register indices reached by the first data byte of a host write.
  localparam logic [7:0] REG_CH_STATE   = 8'h00;
  localparam logic [7:0] REG_GLOBAL     = 8'h01;
  localparam logic [7:0] REG_VOL0       = 8'h02;
  localparam logic [7:0] REG_VOL3       = 8'h05;
  localparam logic [7:0] REG_MISC1      = 8'h06;
  localparam logic [7:0] REG_MISC2      = 8'h07;
  localparam logic [7:0] REG_MISC3      = 8'h08;
  localparam logic [7:0] REG_VOL_RATE   = 8'h09;
  localparam logic [7:0] REG_FAULT_CTRL = 8'h0a;
  localparam logic [7:0] REG_FAULT_STAT = 8'h0b;
  localparam logic [7:0] REG_FORMAT     = 8'h0c;

  // Bit positions inside the control registers.
  localparam int GLB_RESET_BIT   = 7;
  localparam int FLT_CLEAR_BIT   = 7;
  localparam int FLT_CLIP_EN_BIT = 0;
  localparam int FLT_OVT_EN_BIT  = 1;

  // Channel output states.
  localparam logic [1:0] CH_FLOAT = 2'h0;
  localparam logic [1:0] CH_MUTE  = 2'h1;
  localparam logic [1:0] CH_PLAY  = 2'h2;

  // Input framing selection.
  localparam logic [1:0] FMT_AUTO = 2'h0;
  localparam logic [1:0] FMT_I2S  = 2'h1;
  localparam logic [1:0] FMT_TDM  = 2'h2;

  // Reset values.
  localparam logic [7:0] VOL_UNITY   = 8'h80;
  localparam logic [1:0] GAIN_HIGH   = 2'h2;
  localparam logic [1:0] OVT_120C    = 2'h2;
  localparam logic       CUR_LEVEL2  = 1'b1;
  localparam logic       RATIO_64X   = 1'b0;
  localparam logic [2:0] SWF_2M1     = 3'h0;
  localparam logic [2:0] PHASE_45DEG = 3'h0;
  localparam logic [2:0] RATE_1FRAME = 3'h0;

  localparam int SAMPLE_W = 16;
  localparam int VOL_SHIFT = 7;

  typedef struct packed {
    logic       ratio_128x;
    logic       sample_rate_96k;
    logic       overcurrent_level;
    logic [1:0] format_force;
    logic [3:0] lineout;
    logic [1:0] parallel_bridged_pair;
    logic [1:0] gain_sel;
    logic [1:0] ovt_threshold;
    logic [2:0] switching_frequency;
    logic [2:0] phase_offset;
  } acc_cfg_s;

  localparam acc_cfg_s CFG_DEFAULT = '{
    ratio_128x: RATIO_64X, sample_rate_96k: 1'b0, overcurrent_level: CUR_LEVEL2,
    format_force: FMT_AUTO, lineout: 4'h0, parallel_bridged_pair: 2'h0,
    gain_sel: GAIN_HIGH, ovt_threshold: OVT_120C,
    switching_frequency: SWF_2M1, phase_offset: PHASE_45DEG};

  typedef struct packed {
    logic [3:0] clip;
    logic [3:0] overcurrent;
    logic       overtemp_warning;
    logic       overrun;
  } acc_fault_s;

  typedef struct packed {
    logic [1:0]          chan;
    logic [SAMPLE_W-1:0] sample;
  } acc_word_s;

  typedef struct packed {
    logic                valid;
    logic [1:0]          chan;
    logic [SAMPLE_W-1:0] sample;
  } acc_audio_s;

endpackage

// file: hw/acc_fifo.sv
`timescale 1ns/1ns
module acc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rstn,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("acc_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr_r;
  logic [AW:0]      rptr_r;
  logic             push;
  logic             pop;
  logic             empty;

  assign empty    = (wptr_r == rptr_r);
  assign in_ready = !((wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]));
  assign push     = in_valid && in_ready;
  // Read data sits in a register, refilled whenever it is empty or taken.
  assign pop      = !empty && (!out_valid || out_ready);

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
    end
    else
    begin
      if (push)
        wptr_r <= wptr_r + 1'b1;
      if (pop)
        rptr_r <= rptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data  <= mem[rptr_r[AW-1:0]];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end
endmodule

// file: hw/acc_top.sv
// How it works
// [R1] Global float command puts all four channels into float state together.
// [R2] Global mute and play commands set all four channel states at once.
// [R3] Software reset bit returns every setting to its reset value.
// [R4] Each channel holds its own float, mute or play state.
// [R5] Each channel has its own volume, a digital gain on its samples.
// [R6] Channels default to speaker mode; one line-output bit serves channels 1+3, another serves 2+4.
// [R7] Oversampling defaults to 64X, selectable 128X.
// [R8] Channels 1+2 and 3+4 can each form one parallel bridged pair.
// [R9] Over-current threshold has two levels, level two after reset.
// [R10] Input framing is detected automatically, or forced by the host.
// [R11] Host selects the 96 kHz setting for rates above 48 kHz.
// [R12] Over-temperature warning threshold is programmable, 120 C after reset.
// [R13] Switching frequency defaults to 2.1 MHz, lower ones selectable.
// [R14] Channel phase offset defaults to 45 degrees, others selectable.
// [R15] Four analog gain settings, high selected after reset.
// [R16] Volume ramps one step per 1 to 8 frames, default one frame.
// [R17] With clip reporting on, clip status drives the warning pin.
// [R18] With thermal reporting on, over-temperature drives the same warning pin.
// [R19] A host clear command resets all latched faults and warnings.
// [R20] External mute input halts modulation; releasing it restarts it.
// [R21] External standby input enters standby; releasing it resumes operation.
// [R22] Configuration arrives from the host over an I2C slave port.
// [R23] Fault bits stay latched until cleared and are readable anytime.
`timescale 1ns/1ns
module acc_top #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rstn,
  // Host serial port.
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  // Audio link.
  input  wire logic              bclk_i,
  input  wire logic              frame_sync_i,
  input  wire logic              sdata_i,
  // Control pins and fault sensors.
  input  wire logic              mute_req_i,
  input  wire logic              standby_req_i,
  input  wire logic [3:0]        clip_i,
  input  wire logic [3:0]        overcurrent_i,
  input  wire logic              overtemp_i,
  // Processed audio.
  output acc_pkg::acc_audio_s    audio_o,
  input  wire logic              audio_ready,
  // Power stage controls.
  output acc_pkg::acc_cfg_s      cfg_o,
  output logic [3:0]             output_float_state,
  output logic [3:0]             ch_muted,
  output logic                   modulation_en,
  output logic                   standby_o,
  output logic                   warn_n,
  output acc_pkg::acc_fault_s    fault_o
);
  initial
  begin
    if (FIFO_DEPTH < 2)
      $error("acc_top fifo depth too small");
  end

  function automatic logic [acc_pkg::SAMPLE_W-1:0] scale(
    input logic [acc_pkg::SAMPLE_W-1:0] s, input logic [7:0] v);
    logic signed [acc_pkg::SAMPLE_W+8:0] p;
    p = $signed(s) * $signed({1'b0, v});
    return p[acc_pkg::SAMPLE_W+acc_pkg::VOL_SHIFT-1:acc_pkg::VOL_SHIFT];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [9:0] sy1_r;
  logic [9:0] sy2_r;
  logic [9:0] sy3_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sy1_r <= 10'h003;
      sy2_r <= 10'h003;
      sy3_r <= 10'h003;
    end
    else
    begin
      sy1_r <= {overtemp_i, standby_req_i, mute_req_i, sdata_i, frame_sync_i, bclk_i,
                1'b0, 1'b0, scl_i, sda_i};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end
  logic [7:0] flt_s1_r;
  logic [7:0] flt_s2_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flt_s1_r <= 8'h00;
      flt_s2_r <= 8'h00;
    end
    else
    begin
      flt_s1_r <= {clip_i, overcurrent_i};
      flt_s2_r <= flt_s1_r;
    end
  end
  logic sda_s, scl_s, bclk_s, fs_s, sd_s, mute_s, stby_s, ovt_s;
  assign {ovt_s, stby_s, mute_s, sd_s, fs_s, bclk_s} = sy2_r[9:4];
  assign {scl_s, sda_s} = sy2_r[1:0];
  logic scl_rise, scl_fall, i2c_start, i2c_stop, bclk_rise, fs_rise;
  assign scl_rise  = scl_s && !sy3_r[1];
  assign scl_fall  = !scl_s && sy3_r[1];
  assign i2c_start = scl_s && sy3_r[1] && !sda_s && sy3_r[0];
  assign i2c_stop  = scl_s && sy3_r[1] && sda_s && !sy3_r[0];
  assign bclk_rise = bclk_s && !sy3_r[4];
  assign fs_rise   = fs_s && !sy3_r[5];

  ////////////////////////////////////////////////////////////////////////////
  // I2C slave.
  typedef enum logic [6:0] {
    I2C_IDLE  = 7'h01, I2C_ADDR  = 7'h02, I2C_ACK_A = 7'h04, I2C_WR = 7'h08,
    I2C_ACK_W = 7'h10, I2C_RD    = 7'h20, I2C_ACK_R = 7'h40
  } acc_i2c_e;
  acc_i2c_e   i2c_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic       rw_r;
  logic       idx_ok_r;
  logic       nack_r;
  logic [7:0] idx_r;
  logic [7:0] tx_r;
  logic       wr_stb;
  logic [7:0] rd_byte;
  assign wr_stb = scl_fall && (i2c_r == I2C_WR) && (bit_r == 4'h8) && idx_ok_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      i2c_r <= I2C_IDLE; sh_r <= 8'h00; bit_r <= 4'h0; rw_r <= 1'b0;
      idx_ok_r <= 1'b0; nack_r <= 1'b0; idx_r <= 8'h00; tx_r <= 8'h00;
      sda_oe <= 1'b0;
    end
    else if (i2c_start)
    begin
      i2c_r <= I2C_ADDR; bit_r <= 4'h0; sda_oe <= 1'b0; idx_ok_r <= 1'b0;
    end
    else if (i2c_stop)
    begin
      i2c_r <= I2C_IDLE; sda_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      sh_r  <= {sh_r[6:0], sda_s}; // [R22]
      bit_r <= bit_r + 4'h1;
      if (i2c_r == I2C_ACK_R)
        nack_r <= sda_s;
    end
    else if (scl_fall)
    begin
      case (i2c_r)
        I2C_ADDR:
        begin
          if (bit_r == 4'h8)
          begin
            rw_r <= sh_r[0];
            if (sh_r[7:1] == acc_pkg::I2C_DEV_ADDR)
            begin
              i2c_r <= I2C_ACK_A; sda_oe <= 1'b1;
            end
            else
              i2c_r <= I2C_IDLE;
          end
        end
        I2C_ACK_A:
        begin
          bit_r <= 4'h0;
          if (rw_r)
          begin
            i2c_r <= I2C_RD; tx_r <= {rd_byte[6:0], 1'b0}; sda_oe <= !rd_byte[7];
          end
          else
          begin
            i2c_r <= I2C_WR; sda_oe <= 1'b0;
          end
        end
        I2C_WR:
        begin
          if (bit_r == 4'h8)
          begin
            i2c_r <= I2C_ACK_W; sda_oe <= 1'b1;
            if (!idx_ok_r)
              idx_r <= sh_r;
            else
              idx_r <= idx_r + 8'h01;
            idx_ok_r <= 1'b1;
          end
        end
        I2C_ACK_W:
        begin
          i2c_r <= I2C_WR; sda_oe <= 1'b0; bit_r <= 4'h0;
        end
        I2C_RD:
        begin
          if (bit_r == 4'h8)
          begin
            i2c_r <= I2C_ACK_R; sda_oe <= 1'b0; idx_r <= idx_r + 8'h01;
          end
          else
          begin
            sda_oe <= !tx_r[7]; tx_r <= {tx_r[6:0], 1'b0};
          end
        end
        I2C_ACK_R:
        begin
          bit_r <= 4'h0;
          if (nack_r)
          begin
            i2c_r <= I2C_IDLE; sda_oe <= 1'b0;
          end
          else
          begin
            i2c_r <= I2C_RD; tx_r <= {rd_byte[6:0], 1'b0}; sda_oe <= !rd_byte[7];
          end
        end
        default: i2c_r <= I2C_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sda_o <= 1'b0;
    else
      sda_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  logic [1:0] ch_state_r [4];
  logic [7:0] vol_tgt_r [4];
  logic [2:0] vol_rate_r;
  logic       clip_en_r;
  logic       ovt_en_r;
  logic       flt_clear;
  logic       soft_rst;
  acc_pkg::acc_cfg_s cfg_r;
  assign soft_rst  = wr_stb && (idx_r == acc_pkg::REG_GLOBAL) && sh_r[acc_pkg::GLB_RESET_BIT];
  assign flt_clear = wr_stb && (idx_r == acc_pkg::REG_FAULT_CTRL) && sh_r[acc_pkg::FLT_CLEAR_BIT];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_r <= acc_pkg::CFG_DEFAULT; vol_rate_r <= acc_pkg::RATE_1FRAME;
      clip_en_r <= 1'b0; ovt_en_r <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        ch_state_r[i] <= acc_pkg::CH_MUTE; vol_tgt_r[i] <= acc_pkg::VOL_UNITY;
      end
    end
    else if (soft_rst)
    begin
      cfg_r <= acc_pkg::CFG_DEFAULT; vol_rate_r <= acc_pkg::RATE_1FRAME; // [R3]
      clip_en_r <= 1'b0; ovt_en_r <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        ch_state_r[i] <= acc_pkg::CH_MUTE; vol_tgt_r[i] <= acc_pkg::VOL_UNITY;
      end
    end
    else if (wr_stb)
    begin
      case (idx_r)
        acc_pkg::REG_CH_STATE:
          for (int i = 0; i < 4; i++)
            ch_state_r[i] <= sh_r[2*i +: 2]; // [R4]
        acc_pkg::REG_GLOBAL:
          for (int i = 0; i < 4; i++)
            ch_state_r[i] <= sh_r[1:0]; // [R1] [R2]
        acc_pkg::REG_MISC1:
        begin
          cfg_r.ratio_128x        <= sh_r[0]; // [R7]
          cfg_r.sample_rate_96k   <= sh_r[1]; // [R11]
          cfg_r.overcurrent_level <= sh_r[2]; // [R9]
          cfg_r.format_force      <= sh_r[4:3]; // [R10]
        end
        acc_pkg::REG_MISC2:
        begin
          cfg_r.parallel_bridged_pair <= sh_r[1:0]; // [R8]
          cfg_r.gain_sel              <= sh_r[3:2]; // [R15]
          cfg_r.ovt_threshold         <= sh_r[5:4]; // [R12]
          cfg_r.lineout               <= {sh_r[7:6], sh_r[7:6]}; // [R6]
        end
        acc_pkg::REG_MISC3:
        begin
          cfg_r.switching_frequency <= sh_r[2:0]; // [R13]
          cfg_r.phase_offset        <= sh_r[5:3]; // [R14]
        end
        acc_pkg::REG_VOL_RATE:
          vol_rate_r <= sh_r[2:0]; // [R16]
        acc_pkg::REG_FAULT_CTRL:
        begin
          clip_en_r <= sh_r[acc_pkg::FLT_CLIP_EN_BIT];
          ovt_en_r  <= sh_r[acc_pkg::FLT_OVT_EN_BIT];
        end
        default:
          if (idx_r >= acc_pkg::REG_VOL0 && idx_r <= acc_pkg::REG_VOL3)
            vol_tgt_r[2'(idx_r - acc_pkg::REG_VOL0)] <= sh_r; // [R5]
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched faults; a new event wins over a clear in the same cycle.
  acc_pkg::acc_fault_s flt_r;
  logic                overrun;
  logic                tdm_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flt_r <= '0;
    else
    begin
      flt_r.clip             <= (flt_clear ? 4'h0 : flt_r.clip) | flt_s2_r[7:4]; // [R19] [R23]
      flt_r.overcurrent      <= (flt_clear ? 4'h0 : flt_r.overcurrent) | flt_s2_r[3:0];
      flt_r.overtemp_warning <= (!flt_clear && flt_r.overtemp_warning) || ovt_s;
      flt_r.overrun          <= (!flt_clear && flt_r.overrun) || overrun;
    end
  end

  always_comb
  begin
    case (idx_r)
      acc_pkg::REG_CH_STATE:   rd_byte = {ch_state_r[3], ch_state_r[2], ch_state_r[1],
                                          ch_state_r[0]};
      acc_pkg::REG_MISC1:      rd_byte = {3'h0, cfg_r.format_force, cfg_r.overcurrent_level,
                                          cfg_r.sample_rate_96k, cfg_r.ratio_128x};
      acc_pkg::REG_MISC2:      rd_byte = {cfg_r.lineout[1:0], cfg_r.ovt_threshold,
                                          cfg_r.gain_sel, cfg_r.parallel_bridged_pair};
      acc_pkg::REG_MISC3:      rd_byte = {2'h0, cfg_r.phase_offset, cfg_r.switching_frequency};
      acc_pkg::REG_VOL_RATE:   rd_byte = {5'h0, vol_rate_r};
      acc_pkg::REG_FAULT_CTRL: rd_byte = {6'h0, ovt_en_r, clip_en_r};
      acc_pkg::REG_FAULT_STAT: rd_byte = {flt_r.clip, flt_r.overcurrent[3:2] != 2'h0,
                                          flt_r.overcurrent[1:0] != 2'h0,
                                          flt_r.overtemp_warning, flt_r.overrun}; // [R23]
      acc_pkg::REG_FORMAT:     rd_byte = {7'h0, tdm_r};
      default:
        if (idx_r >= acc_pkg::REG_VOL0 && idx_r <= acc_pkg::REG_VOL3)
          rd_byte = vol_tgt_r[2'(idx_r - acc_pkg::REG_VOL0)];
        else
          rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Audio receiver with framing detection.
  logic [acc_pkg::SAMPLE_W-1:0] rx_sh_r;
  logic [3:0]                   rx_cnt_r;
  logic [1:0]                   slot_r;
  logic                         fs_bc_r;
  logic [3:0]                   hi_cnt_r;
  logic                         pend_r;
  acc_pkg::acc_word_s           pend_word_r;
  logic                         fifo_in_ready;
  logic                         use_tdm;
  assign use_tdm = (cfg_r.format_force == acc_pkg::FMT_AUTO) ? tdm_r :
                   (cfg_r.format_force == acc_pkg::FMT_TDM); // [R10]
  assign overrun = bclk_rise && (rx_cnt_r == 4'hf) && pend_r && !fifo_in_ready;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_sh_r <= '0; rx_cnt_r <= 4'h0; slot_r <= 2'h0; fs_bc_r <= 1'b0;
      hi_cnt_r <= 4'h0; tdm_r <= 1'b0; pend_r <= 1'b0; pend_word_r <= '0;
    end
    else
    begin
      if (pend_r && fifo_in_ready)
        pend_r <= 1'b0;
      if (bclk_rise)
      begin
        fs_bc_r <= fs_s;
        rx_sh_r <= {rx_sh_r[acc_pkg::SAMPLE_W-2:0], sd_s};
        if (fs_s)
          hi_cnt_r <= (hi_cnt_r == 4'hf) ? hi_cnt_r : hi_cnt_r + 4'h1;
        // A slot's first bit is taken on the edge that opens it, so its count starts at one.
        if (fs_s && !fs_bc_r)
        begin
          rx_cnt_r <= 4'h1; slot_r <= 2'h0; hi_cnt_r <= 4'h1;
        end
        else if (!fs_s && fs_bc_r && !use_tdm)
        begin
          rx_cnt_r <= 4'h1; slot_r <= 2'h1;
        end
        else
        begin
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_cnt_r == 4'hf)
          begin
            pend_r      <= 1'b1;
            pend_word_r <= '{chan: slot_r, sample: {rx_sh_r[acc_pkg::SAMPLE_W-2:0], sd_s}};
            slot_r      <= slot_r + 2'h1;
          end
        end
        if (!fs_s && fs_bc_r)
          tdm_r <= (hi_cnt_r == 4'h1); // [R10]
      end
    end
  end

  acc_pkg::acc_word_s fifo_out;
  logic               fifo_out_valid;
  logic               fifo_out_ready;
  acc_fifo #(
    .WIDTH ($bits(acc_pkg::acc_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (pend_r),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_word_r),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Volume ramp and sample scaling.
  logic [7:0] vol_cur_r [4];
  logic [2:0] ramp_cnt_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ramp_cnt_r <= 3'h0;
      for (int i = 0; i < 4; i++)
        vol_cur_r[i] <= acc_pkg::VOL_UNITY;
    end
    else if (fs_rise)
    begin
      ramp_cnt_r <= (ramp_cnt_r >= vol_rate_r) ? 3'h0 : ramp_cnt_r + 3'h1; // [R16]
      if (ramp_cnt_r >= vol_rate_r)
        for (int i = 0; i < 4; i++)
          if (vol_cur_r[i] < vol_tgt_r[i])
            vol_cur_r[i] <= vol_cur_r[i] + 8'h01;
          else if (vol_cur_r[i] > vol_tgt_r[i])
            vol_cur_r[i] <= vol_cur_r[i] - 8'h01;
    end
  end

  logic ch_live;
  assign fifo_out_ready = !audio_o.valid || audio_ready;
  assign ch_live = (ch_state_r[fifo_out.chan] == acc_pkg::CH_PLAY) && !mute_s && !stby_s;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      audio_o <= '0;
    else if (fifo_out_ready)
    begin
      audio_o.valid  <= fifo_out_valid;
      audio_o.chan   <= fifo_out.chan;
      audio_o.sample <= ch_live ? scale(fifo_out.sample, vol_cur_r[fifo_out.chan]) : '0; // [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power stage controls and warning pin.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_o <= acc_pkg::CFG_DEFAULT; output_float_state <= 4'hf; ch_muted <= 4'h0;
      modulation_en <= 1'b0; standby_o <= 1'b0; warn_n <= 1'b1; fault_o <= '0;
    end
    else
    begin
      cfg_o         <= cfg_r;
      modulation_en <= !mute_s && !stby_s; // [R20]
      standby_o     <= stby_s; // [R21]
      fault_o       <= flt_r;
      warn_n        <= !((clip_en_r && (flt_r.clip != 4'h0)) ||
                         (ovt_en_r && flt_r.overtemp_warning)); // [R17] [R18]
      for (int i = 0; i < 4; i++)
      begin
        output_float_state[i] <= stby_s || (ch_state_r[i] == acc_pkg::CH_FLOAT); // [R1]
        ch_muted[i]           <= ch_state_r[i] == acc_pkg::CH_MUTE; // [R2]
      end
    end
  end
endmodule

// file: tb/acc_chk_sva.sv
`timescale 1ns/1ns
module acc_chk (
  // Clock and reset.
  input wire logic          clk,
  input wire logic          rstn,
  // Pins seen from outside.
  input wire logic          mute_req_i,
  input wire logic          standby_req_i,
  input wire logic [3:0]    clip_i,
  input wire logic          audio_ready,
  // Block outputs.
  input wire logic          sda_o,
  input wire logic          sda_oe,
  input acc_pkg::acc_audio_s audio_o,
  input wire logic [3:0]    output_float_state,
  input wire logic          modulation_en,
  input wire logic          standby_o,
  input wire logic          warn_n,
  input acc_pkg::acc_fault_s fault_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_pins_idle;
    (!mute_req_i && !standby_req_i) [*6];
  endsequence

  a_mute_halts: assert property (mute_req_i |-> ##[1:4] !modulation_en)
    else $error("modulation not halted by mute pin");
  a_run_resume: assert property (s_pins_idle |-> modulation_en)
    else $error("modulation not restarted");
  a_stby_enter: assert property (standby_req_i |-> ##[1:4] standby_o)
    else $error("standby not entered");
  a_stby_float: assert property (standby_o [*2] |-> output_float_state == 4'hf)
    else $error("channels drive during standby");
  a_warn_quiet: assert property ((fault_o == '0) [*2] |-> warn_n)
    else $error("warning pin low without a fault");
  a_clip_latch: assert property (|clip_i |-> ##[1:4] (fault_o.clip != 4'h0))
    else $error("clip event not latched");
  a_sda_low: assert property (sda_oe |-> !sda_o)
    else $error("data pin driven high");
  a_audio_hold: assert property (audio_o.valid && !audio_ready |=> $stable(audio_o))
    else $error("audio word changed before acceptance");
endmodule

bind acc_top acc_chk i_acc_chk (.*);

// file: tb/acc_src.sv
`timescale 1ns/1ns
module acc_src (
  // Audio link pins.
  output logic bclk,
  output logic fs,
  output logic sd
);
  initial
  begin
    bclk = 1'b0;
    fs = 1'b0;
    sd = 1'b0;
  end

  // One two-slot frame, first bit on the same edge as the sync rise.
  // The bit clock stands still between frames and the data line toggles away.
  task automatic frame(input logic [31:0] w);
    // Link edges are kept clear of the sampling clock's rising edges.
    #5;
    for (int i = 31; i >= 0; i--)
    begin
      fs = (i > 15);
      sd = w[i];
      #160 bclk = 1'b1;
      #160 bclk = 1'b0;
    end
    sd = ~sd;
  endtask
endmodule

// file: tb/test_acc_top.sv
`timescale 1ns/1ns
module test_acc_top;
  logic clk = 1'b0, rstn = 1'b0, scl = 1'b1, sda_d = 1'b1, mute = 1'b0, stby = 1'b0;
  logic ot = 1'b0, ready = 1'b0, sda_oe, mod_en, stby_o, warn_n;
  logic [3:0] clip = 4'h0, flt, mtd;
  logic bclk, fs, sd;
  acc_pkg::acc_audio_s aud;
  acc_pkg::acc_cfg_s cfg, e;
  acc_pkg::acc_fault_s fo;
  int errors = 0, cmp_count = 0;

  initial forever #20 clk = ~clk;

  acc_src i_acc_src (.bclk(bclk), .fs(fs), .sd(sd));
  acc_top i_acc_top (.clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_d & ~sda_oe), .sda_o(),
    .sda_oe(sda_oe), .bclk_i(bclk), .frame_sync_i(fs), .sdata_i(sd), .mute_req_i(mute),
    .standby_req_i(stby), .clip_i(clip), .overcurrent_i(4'h0), .overtemp_i(ot),
    .audio_o(aud), .audio_ready(ready), .cfg_o(cfg), .output_float_state(flt),
    .ch_muted(mtd), .modulation_en(mod_en), .standby_o(stby_o), .warn_n(warn_n),
    .fault_o(fo));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t saw %h wanted %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ibit(input logic b);
    idle(5);
    sda_d <= b;
    idle(5);
    scl <= 1'b1;
    idle(5);
    scl <= 1'b0;
  endtask

  // Start, address, index, data, stop; ack slots leave the line released.
  task automatic iwr(input logic [7:0] idx, input logic [7:0] dat);
    logic [26:0] w;
    w = {acc_pkg::I2C_DEV_ADDR, 1'b0, 1'b1, idx, 1'b1, dat, 1'b1};
    idle(5);
    sda_d <= 1'b0;
    idle(5);
    scl <= 1'b0;
    for (int i = 26; i >= 0; i--) ibit(w[i]);
    idle(5);
    sda_d <= 1'b0;
    idle(5);
    scl <= 1'b1;
    idle(5);
    sda_d <= 1'b1;
    idle(10);
  endtask

  // Start, address with read, eight bits taken while the clock is high, then NACK and stop.
  task automatic ird(output logic [7:0] dat);
    logic [8:0] w;
    w = {acc_pkg::I2C_DEV_ADDR, 1'b1, 1'b1};
    idle(5);
    sda_d <= 1'b0;
    idle(5);
    scl <= 1'b0;
    for (int i = 8; i >= 0; i--) ibit(w[i]);
    for (int i = 7; i >= 0; i--)
    begin
      idle(10);
      scl <= 1'b1;
      idle(3);
      @(negedge clk) dat[i] = sda_d & ~sda_oe;
      idle(2);
      scl <= 1'b0;
    end
    ibit(1'b1);
    idle(5);
    sda_d <= 1'b0;
    idle(5);
    scl <= 1'b1;
    idle(5);
    sda_d <= 1'b1;
    idle(10);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_states;
    chk(cfg, acc_pkg::CFG_DEFAULT);
    chk(mtd, 4'hf);
    iwr(acc_pkg::REG_GLOBAL, 8'h00);
    chk(flt, 4'hf);
    iwr(acc_pkg::REG_GLOBAL, 8'h02);
    chk({flt, mtd}, 8'h00);
    iwr(acc_pkg::REG_CH_STATE, 8'h21);
    chk({flt, mtd}, 8'ha1);
  endtask

  task automatic t_cfg;
    e = acc_pkg::CFG_DEFAULT;
    e.ratio_128x = 1'b1;
    e.sample_rate_96k = 1'b1;
    e.overcurrent_level = 1'b0;
    e.format_force = acc_pkg::FMT_I2S;
    iwr(acc_pkg::REG_MISC1, 8'h0b);
    chk(cfg, e);
    iwr(acc_pkg::REG_GLOBAL, 8'h81);
    chk(cfg, acc_pkg::CFG_DEFAULT);
  endtask

  task automatic t_fault;
    logic [7:0] rd;
    iwr(acc_pkg::REG_FAULT_CTRL, 8'h01);
    clip <= 4'h4;
    idle(1);
    clip <= 4'h0;
    idle(10);
    chk({fo.clip, warn_n}, 5'h08);
    iwr(acc_pkg::REG_FAULT_CTRL, 8'h81);
    chk({fo, warn_n}, 11'h001);
    iwr(acc_pkg::REG_FAULT_CTRL, 8'h02);
    ot <= 1'b1;
    idle(1);
    ot <= 1'b0;
    idle(10);
    chk({fo.overtemp_warning, warn_n}, 2'h2);
    ird(rd);
    chk(rd, 8'h02);
  endtask

  task automatic t_pins;
    mute <= 1'b1;
    idle(8);
    chk(mod_en, 1'b0);
    mute <= 1'b0;
    idle(8);
    chk(mod_en, 1'b1);
    stby <= 1'b1;
    idle(8);
    chk({stby_o, flt}, 5'h1f);
    stby <= 1'b0;
    idle(8);
    chk(stby_o, 1'b0);
  endtask

  task automatic t_audio;
    iwr(acc_pkg::REG_CH_STATE, 8'h0a);
    i_acc_src.frame(32'h1234_0567);
    for (int i = 0; i < 200 && aud.valid !== 1'b1; i++) idle(1);
    chk(aud, {1'b1, 2'h0, 16'h1234});
    if (aud.valid !== 1'b1)
      final_report();
    ready <= 1'b1;
    idle(1);
    ready <= 1'b0;
    idle(8);
    chk(aud, {1'b1, 2'h1, 16'h0567});
  endtask

  initial
  begin
    idle(20);
    rstn <= 1'b1;
    idle(5);
    t_states();
    t_cfg();
    t_fault();
    t_pins();
    t_audio();
    final_report();
  end
endmodule
